/* logic/pfoe_pin_stage.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// per-pin pad stage: registered output value and active-low output enable
// ---------------------------------------------------------------------------
module pfoe_pin_stage (
  input  wire logic                        clock,     // system clock
  input  wire logic                        resetn,    // async reset, active low
  input  wire logic [pfoe_pkg::PORT_W-1:0] driveEn,   // enable bits from register
  input  wire logic [pfoe_pkg::PORT_W-1:0] pinData,   // value to drive per pin
  output logic      [pfoe_pkg::PORT_W-1:0] pinOut,    // pad output value
  output logic      [pfoe_pkg::PORT_W-1:0] pinOeN     // pad output enable, low drives
);

  genvar n;
  generate
    for (n = 0; n < pfoe_pkg::PORT_W; n++) begin : g_pin
      // a disabled pin parks its value low so stale data never reaches the pad
      wire logic outD = driveEn[n] & pinData[n];
      wire logic oeND = ~driveEn[n];

      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          pinOut[n] <= pfoe_pkg::PIN_IDLE[n];
          pinOeN[n] <= ~pfoe_pkg::OE_RESET[n];
        end else begin
          pinOut[n] <= outD;
          pinOeN[n] <= oeND;
        end
      end
    end
  endgenerate

endmodule : pfoe_pin_stage

/* logic/pfoe_pkg.sv */
// ---------------------------------------------------------------------------
// shared constants of the port E/F output enable block
// ---------------------------------------------------------------------------
package pfoe_pkg;

  localparam int          DATA_W      = 32;
  localparam int          PORT_W      = 8;
  localparam int          ADDR_LSB    = 2;

  // register indices; byte address is four times the index
  localparam logic [15:0] E_OE_INDEX  = 16'h30B4;
  localparam logic [15:0] F_OE_INDEX  = 16'h30B5;
  localparam logic [31:0] E_OE_ADDR   = {14'h0000, E_OE_INDEX, 2'h0};
  localparam logic [31:0] F_OE_ADDR   = {14'h0000, F_OE_INDEX, 2'h0};

  localparam logic [7:0]  OE_RESET    = 8'h00;
  localparam logic [7:0]  PIN_IDLE    = 8'h00;
  localparam logic [31:0] RDATA_ZERO  = 32'h00000000;
  localparam logic [23:0] RDATA_PAD   = 24'h000000;

  localparam int          HTRANS_REQ  = 1;     // bit set for NONSEQ and SEQ
  localparam logic [1:0]  LANE0_OFS   = 2'h0;  // byte offset holding bits 7:0
  localparam logic        HRESP_OKAY  = 1'b0;
  localparam logic        HREADY_IDLE = 1'b1;

endpackage : pfoe_pkg

/* logic/pfoe_port_enables.sv */
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
// Summary of operation
// - port E enable register at index 30B4h, all eight bits cleared by reset
// - each port E enable bit is read/write and governs only port E pin n
// - port E bit at 1 drives its pin as output; at 0 output is off
// - port F enable register at index 30B5h, all eight bits cleared by reset
// - each port F enable bit is read/write and governs only port F pin n
// - port F bit at 1 drives its pin as output; at 0 output is off
module pfoe_port_enables (
  input  wire logic                        clock,         // system clock, 100 MHz
  input  wire logic                        resetn,        // async reset, active low
  input  wire logic                        hsel,          // slave select
  input  wire logic [31:0]                 haddr,         // byte address
  input  wire logic [1:0]                  htrans,        // transfer type
  input  wire logic                        hwrite,        // write when high
  input  wire logic [2:0]                  hsize,         // transfer size
  input  wire logic [pfoe_pkg::DATA_W-1:0] hwdata,        // write data
  input  wire logic                        hready,        // bus ready
  output logic                             hreadyout,     // slave ready
  output logic                             hresp,         // response, always OKAY
  output logic      [pfoe_pkg::DATA_W-1:0] hrdata,        // read data
  input  wire logic [pfoe_pkg::PORT_W-1:0] portEData,     // port E output values
  input  wire logic [pfoe_pkg::PORT_W-1:0] portFData,     // port F output values
  output logic      [pfoe_pkg::PORT_W-1:0] portEDriveEn,  // port E enable bits
  output logic      [pfoe_pkg::PORT_W-1:0] portFDriveEn,  // port F enable bits
  output logic      [pfoe_pkg::PORT_W-1:0] portEPinOut,   // port E pad values
  output logic      [pfoe_pkg::PORT_W-1:0] portEPinOeN,   // port E pad enable, low drives
  output logic      [pfoe_pkg::PORT_W-1:0] portFPinOut,   // port F pad values
  output logic      [pfoe_pkg::PORT_W-1:0] portFPinOeN    // port F pad enable, low drives
);

  // ---------------------------------------------------------------------------
  // address phase decode
  // ---------------------------------------------------------------------------
  logic [pfoe_pkg::PORT_W-1:0] portEOe_q;
  logic [pfoe_pkg::PORT_W-1:0] portEOe_d;
  logic [pfoe_pkg::PORT_W-1:0] portFOe_q;
  logic [pfoe_pkg::PORT_W-1:0] portFOe_d;
  logic                        wrPendE_q;
  logic                        wrPendF_q;
  logic                        rdPhaseE_q;
  logic                        rdPhaseF_q;
  logic [pfoe_pkg::DATA_W-1:0] hrdata_q;
  logic [pfoe_pkg::DATA_W-1:0] hrdata_d;

  wire logic addrTaken = hsel & htrans[pfoe_pkg::HTRANS_REQ] & hready;
  wire logic lane0     = (haddr[pfoe_pkg::ADDR_LSB-1:0] == pfoe_pkg::LANE0_OFS);
  wire logic hitE      = (haddr[31:pfoe_pkg::ADDR_LSB]
                          == pfoe_pkg::E_OE_ADDR[31:pfoe_pkg::ADDR_LSB]);
  wire logic hitF      = (haddr[31:pfoe_pkg::ADDR_LSB]
                          == pfoe_pkg::F_OE_ADDR[31:pfoe_pkg::ADDR_LSB]);
  // narrow writes that miss byte lane 0 leave the 8-bit registers alone
  wire logic wrE       = addrTaken & hwrite & hitE & lane0;
  wire logic wrF       = addrTaken & hwrite & hitF & lane0;
  wire logic rdE       = addrTaken & ~hwrite & hitE;
  wire logic rdF       = addrTaken & ~hwrite & hitF;

  // ---------------------------------------------------------------------------
  // register update in the write data phase
  // ---------------------------------------------------------------------------
  assign portEOe_d = wrPendE_q ? hwdata[pfoe_pkg::PORT_W-1:0] : portEOe_q;
  assign portFOe_d = wrPendF_q ? hwdata[pfoe_pkg::PORT_W-1:0] : portFOe_q;

  // ---------------------------------------------------------------------------
  // read data, with bypass of a write still in its data phase
  // ---------------------------------------------------------------------------
  // a read right behind a write to the same register must see the new value,
  // since the register only loads at the end of the write data phase
  wire logic [pfoe_pkg::PORT_W-1:0] curE = portEOe_d;
  wire logic [pfoe_pkg::PORT_W-1:0] curF = portFOe_d;
  wire logic [pfoe_pkg::PORT_W-1:0] rdSel =
    rdE ? curE : (rdF ? curF : pfoe_pkg::OE_RESET);
  assign hrdata_d = (rdE | rdF) ? {pfoe_pkg::RDATA_PAD, rdSel} : pfoe_pkg::RDATA_ZERO;

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      portEOe_q <= pfoe_pkg::OE_RESET;
      portFOe_q <= pfoe_pkg::OE_RESET;
    end else begin
      portEOe_q <= portEOe_d;
      portFOe_q <= portFOe_d;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrPendE_q  <= 1'b0;
      wrPendF_q  <= 1'b0;
      rdPhaseE_q <= 1'b0;
      rdPhaseF_q <= 1'b0;
      hrdata_q   <= pfoe_pkg::RDATA_ZERO;
    end else begin
      wrPendE_q  <= wrE;
      wrPendF_q  <= wrF;
      rdPhaseE_q <= rdE;
      rdPhaseF_q <= rdF;
      hrdata_q   <= hrdata_d;
    end
  end

  // zero wait states: the slave never stalls and never errors
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= pfoe_pkg::HREADY_IDLE;
      hresp     <= pfoe_pkg::HRESP_OKAY;
    end else begin
      hreadyout <= pfoe_pkg::HREADY_IDLE;
      hresp     <= pfoe_pkg::HRESP_OKAY;
    end
  end

  assign hrdata       = hrdata_q;
  assign portEDriveEn = portEOe_q;
  assign portFDriveEn = portFOe_q;

  // ---------------------------------------------------------------------------
  // pad stages
  // ---------------------------------------------------------------------------
  pfoe_pin_stage u_pinE (
    .clock   (clock),
    .resetn  (resetn),
    .driveEn (portEOe_q),
    .pinData (portEData),
    .pinOut  (portEPinOut),
    .pinOeN  (portEPinOeN)
  );

  pfoe_pin_stage u_pinF (
    .clock   (clock),
    .resetn  (resetn),
    .driveEn (portFOe_q),
    .pinData (portFData),
    .pinOut  (portFPinOut),
    .pinOeN  (portFPinOeN)
  );

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  AST_E_RESET_CLEAR: assert property (
    @(posedge clock) disable iff (!resetn)
    $rose(resetn) |-> (portEDriveEn == pfoe_pkg::OE_RESET)
  ) else $error("port E enables not clear after reset");

  AST_F_RESET_CLEAR: assert property (
    @(posedge clock) disable iff (!resetn)
    $rose(resetn) |-> (portFDriveEn == pfoe_pkg::OE_RESET)
  ) else $error("port F enables not clear after reset");

  AST_E_WRITE_LOADS: assert property (
    @(posedge clock) disable iff (!resetn)
    (hsel && htrans[pfoe_pkg::HTRANS_REQ] && hready && hwrite
      && haddr == pfoe_pkg::E_OE_ADDR)
      ##1 1'b1 |=> (portEDriveEn == $past(hwdata[pfoe_pkg::PORT_W-1:0]))
  ) else $error("port E write did not load");

  AST_F_WRITE_LOADS: assert property (
    @(posedge clock) disable iff (!resetn)
    (hsel && htrans[pfoe_pkg::HTRANS_REQ] && hready && hwrite
      && haddr == pfoe_pkg::F_OE_ADDR)
      ##1 1'b1 |=> (portFDriveEn == $past(hwdata[pfoe_pkg::PORT_W-1:0]))
  ) else $error("port F write did not load");

  AST_E_HOLDS: assert property (
    @(posedge clock) disable iff (!resetn)
    !wrPendE_q |=> $stable(portEDriveEn)
  ) else $error("port E enables changed without a port E write");

  AST_F_HOLDS: assert property (
    @(posedge clock) disable iff (!resetn)
    !wrPendF_q |=> $stable(portFDriveEn)
  ) else $error("port F enables changed without a port F write");

  AST_E_READBACK: assert property (
    @(posedge clock) disable iff (!resetn)
    rdPhaseE_q |-> (hrdata == {pfoe_pkg::RDATA_PAD, portEDriveEn})
  ) else $error("port E read data differs from register");

  AST_F_READBACK: assert property (
    @(posedge clock) disable iff (!resetn)
    rdPhaseF_q |-> (hrdata == {pfoe_pkg::RDATA_PAD, portFDriveEn})
  ) else $error("port F read data differs from register");

  AST_E_PAD_ENABLE: assert property (
    @(posedge clock) disable iff (!resetn)
    ##1 (portEPinOeN == ~$past(portEDriveEn))
  ) else $error("port E pad enable does not follow register");

  AST_F_PAD_ENABLE: assert property (
    @(posedge clock) disable iff (!resetn)
    ##1 (portFPinOeN == ~$past(portFDriveEn))
  ) else $error("port F pad enable does not follow register");

  AST_PAD_NO_STRAY_DATA: assert property (
    @(posedge clock) disable iff (!resetn)
    ##1 ((portEPinOut == ($past(portEData) & $past(portEDriveEn)))
      && (portFPinOut == ($past(portFData) & $past(portFDriveEn))))
  ) else $error("disabled pad carries data");

  AST_E_LANE_IGNORED: assert property (
    @(posedge clock) disable iff (!resetn)
    (addrTaken && hwrite && hitE && !lane0) ##1 1'b1 |=> $stable(portEDriveEn)
  ) else $error("port E write outside byte lane 0 changed the register");

  AST_F_LANE_IGNORED: assert property (
    @(posedge clock) disable iff (!resetn)
    (addrTaken && hwrite && hitF && !lane0) ##1 1'b1 |=> $stable(portFDriveEn)
  ) else $error("port F write outside byte lane 0 changed the register");

  AST_RDATA_IDLE_ZERO: assert property (
    @(posedge clock) disable iff (!resetn)
    (!rdPhaseE_q && !rdPhaseF_q) |-> (hrdata == pfoe_pkg::RDATA_ZERO)
  ) else $error("read data not zero outside a read data phase");

  AST_PAD_OFF_WHEN_DISABLED: assert property (
    @(posedge clock) disable iff (!resetn)
    ((portEPinOut & portEPinOeN) == pfoe_pkg::PIN_IDLE)
      && ((portFPinOut & portFPinOeN) == pfoe_pkg::PIN_IDLE)
  ) else $error("pad with output disabled carries a high value");

  AST_BUS_OKAY: assert property (
    @(posedge clock) disable iff (!resetn)
    hreadyout && (hresp == pfoe_pkg::HRESP_OKAY)
  ) else $error("slave stalled or answered with error");

endmodule : pfoe_port_enables

/* sim/pfoe_port_enables_test.sv */
`timescale 1ns/1ps
module pfoe_port_enables_test;
  // --------------------------------------------------------
  // signals and design under test
  // --------------------------------------------------------
  localparam logic [31:0] EA = pfoe_pkg::E_OE_ADDR;
  localparam logic [31:0] FA = pfoe_pkg::F_OE_ADDR;
  logic        clock  = 1'b0;
  logic        resetn = 1'b0;
  logic        hsel   = 1'b0;
  logic [31:0] haddr  = 32'h00000000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize  = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  eData  = 8'h3C;
  logic [7:0]  fData  = 8'h96;
  logic [7:0]  eEn, fEn, eOut, eOeN, fOut, fOeN;
  int          error_cnt = 0;
  int          checks    = 0;

  always #5 clock = ~clock;
  assign hready = hreadyout;

  pfoe_port_enables i_dut (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .portEData(eData),
    .portFData(fData), .portEDriveEn(eEn), .portFDriveEn(fEn), .portEPinOut(eOut),
    .portEPinOeN(eOeN), .portFPinOut(fOut), .portFPinOeN(fOeN));

  // --------------------------------------------------------
  // bus and compare tasks
  // --------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk

  // one single transfer; waits on hready, the watchdog bounds a hang
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
    chk("hresp", 32'h00000000, {31'h00000000, hresp});
  endtask : xfer

  // upper bytes carry junk to show they are ignored
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] unused;
    xfer(a, 1'b1, {24'hA5A5A5, d}, unused);
  endtask : wr

  task automatic rdc(input string what, input logic [31:0] a, input logic [7:0] exp);
    logic [31:0] got;
    xfer(a, 1'b0, 32'h00000000, got);
    chk(what, {24'h000000, exp}, got);
  endtask : rdc

  task automatic pins(input logic [7:0] e, input logic [7:0] f);
    #1;
    chk("portEDriveEn", {24'h000000, e}, {24'h000000, eEn});
    chk("portEPinOeN", {24'h000000, ~e}, {24'h000000, eOeN});
    chk("portEPinOut", {24'h000000, e & eData}, {24'h000000, eOut});
    chk("portFDriveEn", {24'h000000, f}, {24'h000000, fEn});
    chk("portFPinOeN", {24'h000000, ~f}, {24'h000000, fOeN});
    chk("portFPinOut", {24'h000000, f & fData}, {24'h000000, fOut});
    // back on the edge, so the next drive starts right after it
    @(posedge clock);
  endtask : pins

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // --------------------------------------------------------
  // tests
  // --------------------------------------------------------
  initial begin
    logic [7:0] wv;
    @(posedge clock);
    pins(8'h00, 8'h00);
    @(posedge clock);
    resetn <= 1'b1;
    rdc("eReset", EA, 8'h00);
    rdc("fReset", FA, 8'h00);
    $display("test reset values done");
    for (int n = 0; n < 8; n++) begin
      wv = 8'h01 << n;
      // alternate order so a stray write into either port shows up
      if (n % 2 == 1) begin
        wr(FA, ~wv);
        wr(EA, wv);
      end else begin
        wr(EA, wv);
        wr(FA, ~wv);
      end
      rdc("eBit", EA, wv);
      rdc("fBit", FA, ~wv);
      pins(wv, ~wv);
    end
    $display("test walking bits done");
    wr(EA, 8'h5A);
    wr(FA, 8'hC3);
    wr(EA + 32'h1, 8'hFF);
    wr(FA + 32'h2, 8'hFF);
    wr(32'h000030B4, 8'hFF);
    wr(FA + 32'h4, 8'hFF);
    rdc("eUnaligned", EA + 32'h1, 8'h5A);
    rdc("unmapped", 32'h000030B4, 8'h00);
    rdc("fReg", FA, 8'hC3);
    rdc("fUnaligned", FA + 32'h3, 8'hC3);
    rdc("eReg", EA, 8'h5A);
    eData <= 8'hF0;
    fData <= 8'h0F;
    repeat (2) @(posedge clock);
    pins(8'h5A, 8'hC3);
    $display("test decode and pads done");
    resetn <= 1'b0;
    @(posedge clock);
    pins(8'h00, 8'h00);
    @(posedge clock);
    resetn <= 1'b1;
    rdc("eReReset", EA, 8'h00);
    rdc("fReReset", FA, 8'h00);
    $display("test mid-run reset done");
    end_of_test();
  end

  // the tests need about 110 cycles; the 2000-cycle limit leaves ample margin
  initial begin
    #20000;
    error_cnt++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    end_of_test();
  end
endmodule : pfoe_port_enables_test
